// [rtl/fcfp_parser.sv]
// frame control field parser: header decode, frame filter, auto ack and retry decisions
`include "fcfp_regs.svh"
`default_nettype none
module fcfp_parser #(
   parameter int ACK_TURN_CYC = `FCFP_ACK_TURN_CYC
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic frame_start_i,
   input wire logic frame_tx_i,
   input wire logic [7:0] octet_i,
   input wire logic octet_valid_i,
   input wire logic ack_rcvd_i,
   output logic [15:0] fcf_o,
   output logic [2:0] frame_type_o,
   output logic sec_en_o,
   output logic pan_comp_o,
   output logic [1:0] dst_mode_o,
   output logic [1:0] frame_ver_o,
   output logic [1:0] src_mode_o,
   output logic [4:0] hdr_len_o,
   output logic hdr_done_o,
   output logic filt_pass_o,
   output logic ack_send_o,
   output logic ack_pend_o,
   output logic ack_win_o,
   output logic wait_ack_o,
   output logic tx_done_o,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   fcfp_pkg::fcfp_state_s r;
   fcfp_pkg::fcfp_state_s next_r;

   // -------------------------------------------------------------
   // header helpers
   // -------------------------------------------------------------
   // octets of the addressing fields for a given control word
   function automatic logic [4:0] addr_len(input logic [15:0] f);
      logic [4:0] n;
      n = 5'h00;
      if (f[11:10] == `FCFP_AM_SHORT) n = 5'h04;
      if (f[11:10] == `FCFP_AM_EXT) n = 5'h0A;
      if (f[15:14] == `FCFP_AM_SHORT) n = n + 5'h02;
      if (f[15:14] == `FCFP_AM_EXT) n = n + 5'h08;
      // source PAN only when not compressed against a present destination
      if (f[15] && !(f[6] && f[11])) n = n + 5'h02;
      return n;
   endfunction

   // third level filter on the control word alone
   function automatic logic filter(input logic [15:0] f, input logic upld);
      logic ok;
      ok = (f[2:0] <= `FCFP_FT_CMD) || upld;
      if (f[11:10] == `FCFP_AM_RES || f[15:14] == `FCFP_AM_RES) ok = 1'b0;
      // secured 2003-format frames are not handled
      if (f[3] && f[13:12] == `FCFP_FV_2003) ok = 1'b0;
      // both addresses absent is legal only for acknowledgements
      if (f[11:10] == `FCFP_AM_NONE && f[15:14] == `FCFP_AM_NONE && f[2:0] != `FCFP_FT_ACK) ok = 1'b0;
      if (f[6] && !(f[11] && f[15])) ok = 1'b0;
      return ok;
   endfunction

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   // parser, ack timer, retry wait and bus slave share one state word
   always_comb begin
      logic go_end;
      logic aw_take;
      logic w_take;
      logic ar_take;
      go_end = 1'b0;
      aw_take = s_axi_awvalid && r.awready;
      w_take = s_axi_wvalid && r.wready;
      ar_take = s_axi_arvalid && r.arready;
      next_r = r;
      next_r.hdr_done = 1'b0;
      next_r.ack_send = 1'b0;
      next_r.tx_done = 1'b0;
      if (r.win_cnt != 16'h0000) next_r.win_cnt = r.win_cnt - 16'h0001;
      // clear of the retry wait comes first so a new set below wins
      if (ack_rcvd_i || frame_start_i) next_r.wait_ack = 1'b0;
      if (frame_start_i) begin
         next_r.st = fcfp_pkg::ST_FCF_LO;
         next_r.idx = 5'h00;
         next_r.dreq = 1'b0;
         next_r.tx = frame_tx_i;
      end else if (octet_valid_i) begin
         case (r.st)
            fcfp_pkg::ST_FCF_LO: begin
               next_r.fcf[7:0] = octet_i;
               next_r.st = fcfp_pkg::ST_FCF_HI;
            end
            fcfp_pkg::ST_FCF_HI: begin
               next_r.fcf[15:8] = octet_i;
               next_r.alen = addr_len({octet_i, r.fcf[7:0]});
               next_r.bcast = (octet_i[3:2] == `FCFP_AM_SHORT);
               if (r.tx) begin
                  next_r.st = fcfp_pkg::ST_IDLE;
                  next_r.hdr_done = 1'b1;
                  next_r.filt = filter({octet_i, r.fcf[7:0]}, r.ctrl[`FCFP_CTRL_UPLD_RES]);
                  if (r.ctrl[`FCFP_CTRL_ARET_EN]) begin
                     if (r.fcf[5]) next_r.wait_ack = 1'b1;
                     else next_r.tx_done = 1'b1;
                  end
               end else begin
                  next_r.st = fcfp_pkg::ST_SEQ;
               end
            end
            fcfp_pkg::ST_SEQ: begin
               if (r.alen == 5'h00) go_end = 1'b1;
               else next_r.st = fcfp_pkg::ST_ADDR;
            end
            fcfp_pkg::ST_ADDR: begin
               // short destination address all ones is broadcast
               if ((r.idx == 5'h02 || r.idx == 5'h03) && octet_i != `FCFP_BCAST_OCTET) next_r.bcast = 1'b0;
               next_r.idx = r.idx + 5'h01;
               if (r.idx == r.alen - 5'h01) go_end = 1'b1;
            end
            fcfp_pkg::ST_CMD: begin
               next_r.dreq = (octet_i == `FCFP_CMD_DATA_REQ);
               go_end = 1'b1;
            end
            default: next_r.st = fcfp_pkg::ST_IDLE;
         endcase
      end
      // unsecured commands need one more octet to spot a data request
      if (go_end) begin
         if (r.st != fcfp_pkg::ST_CMD && r.fcf[2:0] == `FCFP_FT_CMD && !r.fcf[3]) begin
            next_r.st = fcfp_pkg::ST_CMD;
         end else begin
            next_r.st = fcfp_pkg::ST_IDLE;
            next_r.hdr_done = 1'b1;
            next_r.filt = filter(r.fcf, r.ctrl[`FCFP_CTRL_UPLD_RES]);
            if (r.ctrl[`FCFP_CTRL_AACK_EN] && next_r.filt && r.fcf[5] && !next_r.bcast &&
                (r.fcf[2:0] == `FCFP_FT_DATA || r.fcf[2:0] == `FCFP_FT_CMD) &&
                r.fcf[13:12] <= r.ctrl[`FCFP_CTRL_FVN_LSB +: 2]) begin
               next_r.ack_send = 1'b1;
               next_r.ack_pend = r.ctrl[`FCFP_CTRL_ACK_PEND] && next_r.dreq;
               next_r.win_cnt = ACK_TURN_CYC[15:0];
            end
         end
      end
      next_r.ack_win = (next_r.win_cnt != 16'h0000);
      // write address and data are taken in either order
      if (aw_take) begin
         next_r.aw_ok = 1'b1;
         next_r.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         next_r.w_ok = 1'b1;
         next_r.wdata = s_axi_wdata[5:0];
         next_r.wstrb0 = s_axi_wstrb[0];
      end
      if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
      if (next_r.aw_ok && next_r.w_ok && !next_r.bvalid) begin
         next_r.aw_ok = 1'b0;
         next_r.w_ok = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = `FCFP_RESP_OKAY;
         if (next_r.awaddr == `FCFP_OFS_CTRL) begin
            if (next_r.wstrb0) next_r.ctrl = next_r.wdata;
         end else if (next_r.awaddr != `FCFP_OFS_STATUS) begin
            next_r.bresp = `FCFP_RESP_SLVERR;
         end
      end
      next_r.awready = !next_r.aw_ok;
      next_r.wready = !next_r.w_ok;
      if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
      if (ar_take) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = `FCFP_RESP_OKAY;
         if (s_axi_araddr == `FCFP_OFS_CTRL) next_r.rdata = {26'h0000000, r.ctrl};
         else if (s_axi_araddr == `FCFP_OFS_STATUS) next_r.rdata = {7'h00, r.filt, 3'h0, r.alen, r.fcf};
         else begin
            next_r.rdata = 32'h00000000;
            next_r.rresp = `FCFP_RESP_SLVERR;
         end
      end
      next_r.arready = !next_r.rvalid;
   end

   // -------------------------------------------------------------
   // state register
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '0;
         r.st <= fcfp_pkg::ST_IDLE;
         r.ctrl <= `FCFP_CTRL_RST;
      end else begin
         r <= next_r;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // decoded subfields are plain slices of the captured word
   assign fcf_o = r.fcf;
   assign frame_type_o = r.fcf[2:0];
   assign sec_en_o = r.fcf[3];
   assign pan_comp_o = r.fcf[6];
   assign dst_mode_o = r.fcf[11:10];
   assign frame_ver_o = r.fcf[13:12];
   assign src_mode_o = r.fcf[15:14];
   assign hdr_len_o = r.alen;
   assign hdr_done_o = r.hdr_done;
   assign filt_pass_o = r.filt;
   assign ack_send_o = r.ack_send;
   assign ack_pend_o = r.ack_pend;
   assign ack_win_o = r.ack_win;
   assign wait_ack_o = r.wait_ack;
   assign tx_done_o = r.tx_done;
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   AST_FT_PASS: assert property (hdr_done_o && filt_pass_o |-> frame_type_o <= 3'h3 || r.ctrl[2])
      else $error("reserved frame type passed the filter");
   AST_FT_UPLD: assert property (hdr_done_o && frame_type_o > 3'h3 && !filt_pass_o |->
      !r.ctrl[2] || dst_mode_o == 2'h1 || src_mode_o == 2'h1 || pan_comp_o || sec_en_o || dst_mode_o == 2'h0)
      else $error("reserved frame type rejected with upload enabled");
   AST_DST_RES: assert property (hdr_done_o && dst_mode_o == 2'h1 |-> !filt_pass_o)
      else $error("reserved destination mode passed");
   AST_SRC_RES: assert property (hdr_done_o && src_mode_o == 2'h1 |-> !filt_pass_o)
      else $error("reserved source mode passed");
   AST_SEC: assert property (hdr_done_o && sec_en_o && frame_ver_o == 2'h0 |-> !filt_pass_o)
      else $error("secured 2003 frame passed");
   AST_ACK_REQ: assert property (ack_send_o |-> fcf_o[5] && filt_pass_o && (frame_type_o == 3'h1 || frame_type_o == 3'h3))
      else $error("ack sent for a frame not asking one");
   AST_ACK_WIN: assert property (ack_send_o |-> ack_win_o ##1 ack_win_o)
      else $error("ack window not open after decision");
   AST_ACK_VER: assert property (ack_send_o |-> frame_ver_o <= r.ctrl[5:4])
      else $error("ack sent against version policy");
   AST_PEND: assert property (ack_send_o && !r.ctrl[3] |-> !ack_pend_o)
      else $error("pending bit set without setting");
   AST_RETRY_WAIT: assert property (r.st == fcfp_pkg::ST_FCF_HI && r.tx && octet_valid_i &&
      !frame_start_i && r.ctrl[1] && r.fcf[5] |=> wait_ack_o && !tx_done_o)
      else $error("retry state did not wait for ack");
   AST_RETRY_DONE: assert property (r.st == fcfp_pkg::ST_FCF_HI && r.tx && octet_valid_i &&
      !frame_start_i && r.ctrl[1] && !r.fcf[5] |=> tx_done_o)
      else $error("retry state did not finish at once");
   // an arriving ack ends the retry wait unless a new wait is armed in the same cycle
   AST_WAIT_CLR: assert property (ack_rcvd_i && !(r.st == fcfp_pkg::ST_FCF_HI && octet_valid_i) |=> !wait_ack_o)
      else $error("retry wait kept after ack");
   // length restated from the subfields, not from the parser's own helper
   AST_LEN: assert property (hdr_done_o |-> hdr_len_o ==
      (dst_mode_o == 2'h2 ? 5'h04 : (dst_mode_o == 2'h3 ? 5'h0A : 5'h00)) +
      (src_mode_o == 2'h2 ? 5'h02 : (src_mode_o == 2'h3 ? 5'h08 : 5'h00)) +
      ((src_mode_o[1] && !(pan_comp_o && dst_mode_o[1])) ? 5'h02 : 5'h00))
      else $error("addressing length mismatch");
   AST_NO_ADDR: assert property (hdr_done_o && dst_mode_o == 2'h0 && src_mode_o == 2'h0 && frame_type_o != 3'h2 |->
      !filt_pass_o)
      else $error("frame without addresses passed");
   AST_PANC: assert property (hdr_done_o && pan_comp_o && !(dst_mode_o[1] && src_mode_o[1]) |-> !filt_pass_o)
      else $error("compression without both addresses passed");
endmodule
`default_nettype wire

// [rtl/fcfp_regs.svh]
// register offsets, field positions, reset values and timing counts of the frame control parser
`ifndef FCFP_REGS_SVH
`define FCFP_REGS_SVH
`define FCFP_OFS_CTRL 8'h00
`define FCFP_OFS_STATUS 8'h04
`define FCFP_CTRL_AACK_EN 0
`define FCFP_CTRL_ARET_EN 1
`define FCFP_CTRL_UPLD_RES 2
`define FCFP_CTRL_ACK_PEND 3
`define FCFP_CTRL_FVN_LSB 4
`define FCFP_CTRL_RST 6'h00
`define FCFP_FT_DATA 3'h1
`define FCFP_FT_ACK 3'h2
`define FCFP_FT_CMD 3'h3
`define FCFP_AM_NONE 2'h0
`define FCFP_AM_RES 2'h1
`define FCFP_AM_SHORT 2'h2
`define FCFP_AM_EXT 2'h3
`define FCFP_FV_2003 2'h0
`define FCFP_CMD_DATA_REQ 8'h04
`define FCFP_BCAST_OCTET 8'hFF
`define FCFP_CLK_MHZ 40
`define FCFP_ACK_TURN_US 192
`define FCFP_ACK_TURN_CYC (`FCFP_ACK_TURN_US * `FCFP_CLK_MHZ)
`define FCFP_RESP_OKAY 2'h0
`define FCFP_RESP_SLVERR 2'h2
`endif

// [rtl/fcfp_pkg.sv]
// types of the frame control parser
`default_nettype none
package fcfp_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_FCF_LO, ST_FCF_HI, ST_SEQ, ST_ADDR, ST_CMD} fcfp_state_e;
   typedef struct packed {
      fcfp_state_e st;
      logic [15:0] fcf;
      logic [4:0] alen;
      logic [4:0] idx;
      logic bcast;
      logic dreq;
      logic tx;
      logic filt;
      logic hdr_done;
      logic ack_send;
      logic ack_pend;
      logic ack_win;
      logic [15:0] win_cnt;
      logic wait_ack;
      logic tx_done;
      logic [5:0] ctrl;
      logic awready;
      logic aw_ok;
      logic [7:0] awaddr;
      logic wready;
      logic w_ok;
      logic [5:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fcfp_state_s;
endpackage
`default_nettype wire

// [test/fcfp_node_model.sv]
// remote radio node model: streams frame octets into the parser and answers with acks
`default_nettype none
module fcfp_node_model (
   input wire logic clk_sys_i,
   output logic frame_start_o,
   output logic frame_tx_o,
   output logic [7:0] octet_o,
   output logic octet_valid_o,
   output logic ack_rcvd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // frame stream
   // ----------------------------------------
   initial begin
      frame_start_o = 1'h0;
      frame_tx_o = 1'h0;
      octet_o = 8'h00;
      octet_valid_o = 1'h0;
      ack_rcvd_o = 1'h0;
   end
   // gap idles the line between octets; idle data shows the inverse so stale octets never look valid
   task automatic send(input logic tx, input logic [7:0] q[$], input int gap);
      int i;
      @(posedge clk_sys_i);
      frame_start_o <= 1'h1;
      frame_tx_o <= tx;
      for (i = 0; i < q.size(); i++) begin
         @(posedge clk_sys_i);
         frame_start_o <= 1'h0;
         octet_o <= q[i];
         octet_valid_o <= 1'h1;
         repeat (gap) begin
            @(posedge clk_sys_i);
            octet_valid_o <= 1'h0;
            octet_o <= ~q[i];
         end
      end
      @(posedge clk_sys_i);
      octet_valid_o <= 1'h0;
      octet_o <= ~q[q.size() - 1];
   endtask
   // one-cycle ack arrival
   task automatic ack_pulse();
      @(posedge clk_sys_i);
      ack_rcvd_o <= 1'h1;
      @(posedge clk_sys_i);
      ack_rcvd_o <= 1'h0;
   endtask
endmodule
`default_nettype wire

// [test/test_frame_control_field_parser.sv]
// self-checking bench of the frame control field parser
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("MISMATCH at %0t got %0h exp %0h", $time, (g), (e)); end end
module test_frame_control_field_parser;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WIN = 20;
   logic clk_sys_i = 1'h0;
   logic resetn_i = 1'h0;
   logic frame_start_i, frame_tx_i, octet_valid_i, ack_rcvd_i;
   logic [7:0] octet_i;
   logic [15:0] fcf_o;
   logic [2:0] frame_type_o;
   logic [1:0] dst_mode_o, frame_ver_o, src_mode_o, s_axi_bresp, s_axi_rresp;
   logic [4:0] hdr_len_o;
   logic sec_en_o, pan_comp_o, hdr_done_o, filt_pass_o, ack_send_o, ack_pend_o, ack_win_o, wait_ack_o, tx_done_o;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, exp_stat;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] ctrl = 6'h00;
   logic [7:0] t;
   logic [1:0] br;
   int p, error_cnt = 0, num_checks = 0, win_len = 0, last_win = 0;
   fcfp_parser #(.ACK_TURN_CYC(WIN)) uut (.clk_sys_i, .resetn_i, .frame_start_i, .frame_tx_i, .octet_i,
      .octet_valid_i, .ack_rcvd_i, .fcf_o, .frame_type_o, .sec_en_o, .pan_comp_o, .dst_mode_o, .frame_ver_o,
      .src_mode_o, .hdr_len_o, .hdr_done_o, .filt_pass_o, .ack_send_o, .ack_pend_o, .ack_win_o, .wait_ack_o,
      .tx_done_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fcfp_node_model node (.clk_sys_i, .frame_start_o(frame_start_i), .frame_tx_o(frame_tx_i), .octet_o(octet_i),
      .octet_valid_o(octet_valid_i), .ack_rcvd_o(ack_rcvd_i));
   // ----------------------------------------
   // clock, ack window length, register bus
   // ----------------------------------------
   initial forever #12.5 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) begin
      if (ack_win_o === 1'h1) win_len++;
      else if (win_len != 0) begin
         last_win = win_len;
         win_len = 0;
      end
   end
   // ready is sampled at the negedge before the edge, so releases never race the slave's updates
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done, ra, rw;
      done = 1'h0;
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!done) begin
         @(negedge clk_sys_i);
         done = s_axi_bvalid;
         r = s_axi_bresp;
         ra = s_axi_awready;
         rw = s_axi_wready;
         @(posedge clk_sys_i);
         if (ra) s_axi_awvalid <= 1'h0;
         if (rw) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
   endtask
   task automatic creg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic done, ra;
      logic [31:0] d;
      logic [1:0] r;
      done = 1'h0;
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done) begin
         @(negedge clk_sys_i);
         done = s_axi_rvalid;
         ra = s_axi_arready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys_i);
         if (ra) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      `CHK(d, e)
      `CHK(r, er)
   endtask
   task automatic setc(input logic [5:0] v);
      logic [1:0] r;
      wr(8'h00, {26'h0, v}, r);
      ctrl = v;
      `CHK(r, 2'h0)
      creg(8'h00, {26'h0, v}, 2'h0);
   endtask
   // ----------------------------------------
   // frames
   // ----------------------------------------
   task automatic rx(input logic [15:0] f, input logic bc);
      logic [7:0] q[$];
      logic [4:0] len;
      logic pass, ack, fp, as, ap;
      int n;
      q = '{f[7:0], f[15:8], 8'h5A};
      if (f[11]) repeat (f[10] ? 10 : 4) q.push_back(bc ? 8'hFF : 8'h3C);
      if (f[15]) repeat ((f[14] ? 8 : 2) + ((f[6] && f[11]) ? 0 : 2)) q.push_back(8'h66);
      len = 5'(q.size() - 3);
      q = {q, 8'h04, 8'h11, 8'h22, 8'h33};
      pass = (f[2:0] < 3'h4 || ctrl[2]) && f[11:10] != 2'h1 && f[15:14] != 2'h1 && !(f[3] && f[13:12] == 2'h0)
         && !(f[11:10] == 2'h0 && f[15:14] == 2'h0 && f[2:0] != 3'h2) && !(f[6] && !(f[11] && f[15]));
      ack = ctrl[0] && pass && f[5] && (f[2:0] == 3'h1 || f[2:0] == 3'h3) && !bc && f[13:12] <= ctrl[5:4];
      fork
         node.send(1'h0, q, 0);
         begin
            n = 0;
            do begin
               @(negedge clk_sys_i);
               n++;
            end while (hdr_done_o !== 1'h1 && n < 60);
            fp = filt_pass_o;
            as = ack_send_o;
            ap = ack_pend_o;
         end
      join
      `CHK(n < 60, 1'h1)
      `CHK(fcf_o, f)
      `CHK({src_mode_o, frame_ver_o, dst_mode_o, pan_comp_o, sec_en_o, frame_type_o}, {f[15:10], f[6], f[3:0]})
      if (f[11:10] != 2'h1 && f[15:14] != 2'h1) `CHK(hdr_len_o, len)
      `CHK(fp, pass)
      `CHK(as, ack)
      if (ack) `CHK(ap, f[2:0] == 3'h3 && !f[3] && ctrl[3])
      exp_stat = {7'h00, pass, 3'h0, len, f};
   endtask
   task automatic tx(input logic [15:0] f);
      logic [7:0] q[$];
      logic wa, td;
      int n;
      q = '{f[7:0], f[15:8]};
      fork
         node.send(1'h1, q, 1);
         begin
            n = 0;
            do begin
               @(negedge clk_sys_i);
               n++;
            end while (hdr_done_o !== 1'h1 && n < 60);
            wa = wait_ack_o;
            td = tx_done_o;
         end
      join
      `CHK({n < 60, wa, td, fcf_o}, {1'h1, f[5], !f[5], f})
      if (f[5]) begin
         node.ack_pulse();
         @(negedge clk_sys_i);
         `CHK(wait_ack_o, 1'h0)
      end
   endtask
   // ----------------------------------------
   // sequence and verdict
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      creg(8'h00, 32'h0, 2'h0);
      creg(8'h08, 32'h0, 2'h2);
      // unmapped write errors, status write and a cleared low strobe leave control untouched
      wr(8'h08, 32'h0000003F, br);
      `CHK(br, 2'h2)
      wr(8'h04, 32'h0000003F, br);
      `CHK(br, 2'h0)
      s_axi_wstrb <= 4'h0;
      wr(8'h00, 32'h0000003F, br);
      s_axi_wstrb <= 4'hF;
      `CHK(br, 2'h0)
      creg(8'h00, 32'h0, 2'h0);
      for (p = 0; p < 2; p++) begin
         setc(p ? 6'h3D : 6'h00);
         for (t = 0; t < 8; t++) rx({8'h98, 8'h60 | t}, 1'h0);
      end
      creg(8'h04, exp_stat, 2'h0);
      rx(16'h9861, 1'h1);
      repeat (30) @(posedge clk_sys_i);
      rx(16'h9861, 1'h0);
      repeat (30) @(posedge clk_sys_i);
      `CHK(last_win, WIN)
      for (t = 0; t < 64; t++) rx({t[3:2], 2'h1, t[1:0], 3'h0, t[4], 4'h8, t[5], 1'h1}, 1'h0);
      // an acknowledgement carries no addresses and still passes
      rx(16'h0002, 1'h0);
      creg(8'h04, exp_stat, 2'h0);
      for (p = 0; p < 4; p++) begin
         setc({2'(p), 4'h1});
         for (t = 0; t < 8; t++) rx({2'h2, t[1:0], 2'h2, 3'h0, 3'h6, t[2], 3'h1}, 1'h0);
      end
      setc(6'h02);
      tx(16'h9861);
      tx(16'h9841);
      complete_run();
   end
endmodule
`default_nettype wire
